// >>> hdl/ioxh_ctrl.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ioxh_ctrl import ioxh_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic changeAlertN,
  output logic busResetN
);
  ioxh_state_type stateReg, stateNext;
  logic [6:0] qtrReg, qtrNext;
  logic tick;
  logic [1:0] phReg, phNext;
  logic [3:0] bitReg, bitNext;
  logic [2:0] stepReg, stepNext;
  logic [7:0] shReg, shNext;
  logic ackReg, ackNext;
  logic sclReg, sclNext;
  logic oeNReg, oeNNext;
  logic rnwReg, rnwNext;
  logic aselReg, aselNext;
  logic busRstNReg, busRstNNext;
  logic [7:0] cmdReg, cmdNext;
  logic [7:0] wdReg, wdNext;
  logic [7:0] rxReg, rxNext;
  logic nackReg, nackNext;
  logic doneReg, doneNext;
  logic [7:0] rdReg, rdNext;
  logic sdaOutReg;
  logic sdaMeta, sdaSync, alertMeta, alertSync;
  logic rx, dirCmd;

  // pin inputs: two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      alertMeta <= 1'b1;
      alertSync <= 1'b1;
    end else begin
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      alertMeta <= changeAlertN;
      alertSync <= alertMeta;
    end
  end

  // quarter-bit timer; held loaded while idle
  always_comb begin
    tick = 1'b0;
    qtrNext = qtrReg - 7'h01;
    if (stateReg == ST_IDLE) begin
      qtrNext = QTR_LOAD;
    end else if (qtrReg == 7'h00) begin
      tick = 1'b1;
      qtrNext = QTR_LOAD;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qtrReg <= QTR_LOAD;
    end else begin
      qtrReg <= qtrNext;
    end
  end

  assign rx = (stepReg == STEP_READ);
  assign dirCmd = (cmdReg == CMD_DIR_A) || (cmdReg == CMD_DIR_B);

  function automatic logic [7:0] byteOf(input logic [2:0] s);
    logic [7:0] b;
    b = 8'h00;
    case (s)
      STEP_ADDRW: b = {ADDR_HI, aselReg, ADDR_LO, DIR_WR};
      STEP_ADDRR: b = {ADDR_HI, aselReg, ADDR_LO, DIR_RD};
      STEP_CMD: b = cmdReg;
      STEP_DATA: b = dirCmd ? (wdReg & DIR_KEEP) : wdReg;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb begin
    stateNext = stateReg;
    phNext = phReg;
    bitNext = bitReg;
    stepNext = stepReg;
    shNext = shReg;
    ackNext = ackReg;
    sclNext = sclReg;
    oeNNext = oeNReg;
    rnwNext = rnwReg;
    aselNext = aselReg;
    busRstNNext = busRstNReg;
    cmdNext = cmdReg;
    wdNext = wdReg;
    rxNext = rxReg;
    nackNext = nackReg;
    doneNext = doneReg;
    rdNext = 8'h00;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: begin
          rdNext[CTRL_RNW] = rnwReg;
          rdNext[CTRL_ASEL] = aselReg;
          rdNext[CTRL_RST] = !busRstNReg;
        end
        REG_CMD: rdNext = cmdReg;
        REG_WDATA: rdNext = wdReg;
        REG_STAT: begin
          rdNext[STAT_BUSY] = (stateReg != ST_IDLE);
          rdNext[STAT_NACK] = nackReg;
          rdNext[STAT_ALERT] = !alertSync;
          rdNext[STAT_DONE] = doneReg;
        end
        REG_RDATA: rdNext = rxReg;
        default: rdNext = 8'h00;
      endcase
    end
    if (regWr) begin
      case (regAddr)
        REG_CTRL: begin
          rnwNext = regWrData[CTRL_RNW];
          aselNext = regWrData[CTRL_ASEL];
          busRstNNext = !regWrData[CTRL_RST];
          // a go while busy or while holding reset is dropped
          if (regWrData[CTRL_GO] && !regWrData[CTRL_RST] &&
              stateReg == ST_IDLE && busRstNReg) begin
            stateNext = ST_START;
            stepNext = STEP_ADDRW;
            phNext = 2'h0;
            nackNext = 1'b0;
            doneNext = 1'b0;
          end
        end
        REG_CMD: cmdNext = regWrData;
        REG_WDATA: wdNext = regWrData;
        default: ;
      endcase
    end
    if (!busRstNReg) begin
      // device interface is being cleared: abandon and release lines
      stateNext = ST_IDLE;
      sclNext = 1'b1;
      oeNNext = 1'b1;
    end else if (tick) begin
      phNext = phReg + 2'h1;
      unique case (stateReg)
        ST_START: begin
          case (phReg)
            2'h0: oeNNext = 1'b1;
            2'h1: sclNext = 1'b1;
            2'h2: oeNNext = 1'b0;
            default: begin
              sclNext = 1'b0;
              stateNext = ST_BIT;
              bitNext = 4'h0;
              shNext = byteOf(stepReg);
            end
          endcase
        end
        ST_BIT: begin
          case (phReg)
            // data set a quarter after clock fell, never while high
            2'h0: oeNNext = bitReg == ACK_BIT || rx || shReg[7];
            2'h1: sclNext = 1'b1;
            2'h2: begin
              if (bitReg == ACK_BIT) begin
                ackNext = sdaSync;
              end else if (rx) begin
                shNext = {shReg[6:0], sdaSync};
              end
            end
            default: begin
              sclNext = 1'b0;
              if (bitReg != ACK_BIT) begin
                bitNext = bitReg + 4'h1;
                if (!rx) begin
                  shNext = {shReg[6:0], 1'b0};
                end
              end else if (!rx && ackReg) begin
                nackNext = 1'b1;
                stateNext = ST_STOP;
              end else begin
                bitNext = 4'h0;
                case (stepReg)
                  STEP_ADDRW: begin
                    stepNext = STEP_CMD;
                    shNext = byteOf(STEP_CMD);
                  end
                  STEP_CMD: begin
                    if (rnwReg) begin
                      stepNext = STEP_ADDRR;
                      stateNext = ST_START;
                    end else begin
                      stepNext = STEP_DATA;
                      shNext = byteOf(STEP_DATA);
                    end
                  end
                  STEP_ADDRR: stepNext = STEP_READ;
                  default: begin
                    // single byte read ends with no-ack then stop
                    if (rx) begin
                      rxNext = shReg;
                    end
                    stateNext = ST_STOP;
                  end
                endcase
              end
            end
          endcase
        end
        ST_STOP: begin
          case (phReg)
            2'h0: oeNNext = 1'b0;
            2'h1: sclNext = 1'b1;
            2'h2: oeNNext = 1'b1;
            default: begin
              stateNext = ST_IDLE;
              doneNext = 1'b1;
            end
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ST_IDLE;
      phReg <= 2'h0;
      bitReg <= 4'h0;
      stepReg <= STEP_ADDRW;
      shReg <= 8'h00;
      ackReg <= 1'b1;
      sclReg <= 1'b1;
      oeNReg <= 1'b1;
      rnwReg <= 1'b0;
      aselReg <= 1'b0;
      busRstNReg <= 1'b1;
      cmdReg <= 8'h00;
      wdReg <= 8'h00;
      rxReg <= 8'h00;
      nackReg <= 1'b0;
      doneReg <= 1'b0;
      rdReg <= 8'h00;
      sdaOutReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      phReg <= phNext;
      bitReg <= bitNext;
      stepReg <= stepNext;
      shReg <= shNext;
      ackReg <= ackNext;
      sclReg <= sclNext;
      oeNReg <= oeNNext;
      rnwReg <= rnwNext;
      aselReg <= aselNext;
      busRstNReg <= busRstNNext;
      cmdReg <= cmdNext;
      wdReg <= wdNext;
      rxReg <= rxNext;
      nackReg <= nackNext;
      doneReg <= doneNext;
      rdReg <= rdNext;
      sdaOutReg <= 1'b0;
    end
  end

  assign regRdData = rdReg;
  assign scl = sclReg;
  assign sdaOut = sdaOutReg;
  assign sdaOeN = oeNReg;
  assign busResetN = busRstNReg;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_idle_lines_high: assert property (
    stateReg == ST_IDLE |-> scl && sdaOeN)
    else $error("bus not released while idle");
  chk_start_shape: assert property (
    scl && $fell(sdaOeN) |-> stateReg == ST_START)
    else $error("data fell under high clock outside start");
  chk_stop_shape: assert property (
    scl && $rose(sdaOeN) |-> stateReg == ST_STOP || !busRstNReg)
    else $error("data rose under high clock outside stop");
  chk_data_stable: assert property (
    stateReg == ST_BIT && scl && $past(scl) |-> $stable(sdaOeN))
    else $error("data changed while clock high");
  chk_clock_high_len: assert property (
    $rose(scl) && busRstNReg |-> scl [*8])
    else $error("clock high phase too short");
  chk_addr_byte: assert property (
    stateReg == ST_BIT && bitReg == 4'h0 && phReg == 2'h0 &&
    (stepReg == STEP_ADDRW || stepReg == STEP_ADDRR) |->
    shReg[7:3] == ADDR_HI && shReg[1] == ADDR_LO &&
    shReg[0] == (stepReg == STEP_ADDRR))
    else $error("wrong device address or direction");
  chk_ack_released: assert property (
    stateReg == ST_BIT && bitReg == ACK_BIT && phReg != 2'h0 |-> sdaOeN)
    else $error("master drove the acknowledge slot");
  chk_dir_low_zero: assert property (
    stateReg == ST_BIT && stepReg == STEP_DATA && dirCmd &&
    bitReg >= 4'h4 && bitReg < ACK_BIT && phReg != 2'h0 |-> !sdaOeN)
    else $error("direction write low bits not zero");
  chk_read_order: assert property (
    $changed(stepReg) && stepReg == STEP_ADDRR |->
    stateReg == ST_START && $past(stepReg) == STEP_CMD)
    else $error("read address without command and restart");
  chk_go_starts: assert property (
    regWr && regAddr == REG_CTRL && regWrData[CTRL_GO] &&
    !regWrData[CTRL_RST] && busRstNReg && stateReg == ST_IDLE |=>
    stateReg == ST_START ##1 scl [*8])
    else $error("go did not start a transfer");

  cov_write_done: cover property (
    stateReg == ST_STOP && stepReg == STEP_DATA ##1 doneReg);
  cov_read_done: cover property (
    $changed(rxReg) && stateReg == ST_STOP);
  cov_nack: cover property ($rose(nackReg));
  cov_restart: cover property (
    stateReg == ST_START && stepReg == STEP_ADDRR && tick);
endmodule
`default_nettype wire

// >>> hdl/ioxh_pkg.sv
package ioxh_pkg;
  // clock and link timing
  localparam int CLK_NS = 8;
  localparam int QTR_NS = 650;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] QTR_LOAD = 7'(QTR_CYC - 1);
  // device address: fixed upper bits, pin bit, fixed low bit
  localparam logic [4:0] ADDR_HI = 5'h16;
  localparam logic ADDR_LO = 1'b0;
  localparam logic DIR_WR = 1'b0;
  localparam logic DIR_RD = 1'b1;
  // command codes of the device
  localparam logic [7:0] CMD_IN_A = 8'h00;
  localparam logic [7:0] CMD_IN_B = 8'h01;
  localparam logic [7:0] CMD_OUT_A = 8'h02;
  localparam logic [7:0] CMD_OUT_B = 8'h03;
  localparam logic [7:0] CMD_DIR_A = 8'h04;
  localparam logic [7:0] CMD_DIR_B = 8'h05;
  localparam logic [7:0] CMD_MASK_A = 8'h06;
  localparam logic [7:0] CMD_MASK_B = 8'h07;
  localparam logic [7:0] DIR_KEEP = 8'hF0;
  // own register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RNW = 1;
  localparam int CTRL_ASEL = 2;
  localparam int CTRL_RST = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_ALERT = 2;
  localparam int STAT_DONE = 3;
  // byte steps of a transaction
  localparam logic [2:0] STEP_ADDRW = 3'h0;
  localparam logic [2:0] STEP_CMD = 3'h1;
  localparam logic [2:0] STEP_DATA = 3'h2;
  localparam logic [2:0] STEP_ADDRR = 3'h3;
  localparam logic [2:0] STEP_READ = 3'h4;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BIT = 4'h4,
    ST_STOP = 4'h8
  } ioxh_state_type;
endpackage

// >>> tb/ioxh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module ioxh_dev_model #(
  parameter bit ASEL_PIN = 1'b1
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic busResetN,
  input wire logic [7:0] pins,
  output logic changeAlertN,
  output var logic pull
);
  // pins[7:4] are group A, pins[3:0] group B
  logic [7:0] regs [0:7];
  logic [7:0] sh = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [3:0] snapA = 4'h0;
  logic [3:0] snapB = 4'h0;
  logic act = 1'b0;
  logic rx = 1'b1;
  logic first = 1'b0;
  logic cmdNext = 1'b0;
  logic latA = 1'b0;
  logic latB = 1'b0;
  logic lowErr = 1'b0;
  int cnt = 0;
  initial begin
    pull = 1'b0;
    for (int i = 0; i < 8; i++) regs[i] = 8'h00;
    regs[2] = ASEL_PIN ? 8'hF0 : 8'h00;
    regs[3] = ASEL_PIN ? 8'hF0 : 8'h00;
  end
  assign changeAlertN = !(latA || latB);
  // level compare, so a glitch that returns still latches; compared to
  // the snapshot sent, so changes during a read still alert
  always @(pins) begin
    if (|((pins[7:4] ^ snapA) & regs[4][7:4] & ~regs[6][7:4]))
      latA = 1'b1;
    if (|((pins[3:0] ^ snapB) & regs[5][7:4] & ~regs[7][7:4]))
      latB = 1'b1;
  end
  always @(negedge sda) if (scl === 1'b1 && busResetN) begin
    act = 1'b1;
    cnt = 0;
    rx = 1'b1;
    first = 1'b1;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    pull = 1'b0;
  end
  always @(negedge busResetN) begin
    act = 1'b0;
    pull = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (rx && cnt < 8) sh = {sh[6:0], sda};
    if (!rx && cnt == 8 && sda === 1'b1) act = 1'b0;
    cnt = cnt + 1;
  end
  always @(negedge scl) if (act) begin
    if (cnt == 8 && rx) begin
      // a foreign address gets no ack at all, not even a short pulse
      pull = !first || sh[7:1] === {5'h16, ASEL_PIN, 1'b0};
      if (first) begin
        first = 1'b0;
        if (!pull) begin
          act = 1'b0;
        end else if (sh[0]) begin
          rx = 1'b0;
          if (!cmd[0]) begin
            snapA = pins[7:4];
            latA = 1'b0;
          end else begin
            snapB = pins[3:0];
            latB = 1'b0;
          end
          if (cmd < 8'h02)
            tx = cmd[0] ? {pins[3:0], 4'h0} : {pins[7:4], 4'h0};
          else tx = regs[cmd[2:0]];
        end else cmdNext = 1'b1;
      end else if (cmdNext) begin
        cmd = sh;
        cmdNext = 1'b0;
      end else begin
        if (cmd[2:1] == 2'h2 && sh[3:0] != 4'h0) lowErr = 1'b1;
        if (cmd >= 8'h02 && cmd < 8'h08)
          regs[cmd[2:0]] = sh & 8'hF0;
      end
    end else if (cnt == 9) begin
      cnt = 0;
      pull = !rx && !tx[7];
    end else pull = !rx && cnt < 8 && !tx[7 - cnt];
  end
endmodule
`default_nettype wire

// >>> tb/tb_ioxh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ioxh_ctrl import ioxh_pkg::*;;
  logic clk, rst_n, regWr, regRd, scl, sdaOut, sdaOeN, busResetN;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, pins, d;
  wire logic sda;
  wire logic alertN;
  wire logic devPull;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  assign sda = ((!sdaOeN) ? sdaOut : 1'b1) & !devPull;
  ioxh_ctrl dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .changeAlertN(alertN), .busResetN(busResetN));
  ioxh_dev_model #(.ASEL_PIN(1'b1)) dev (.scl(scl), .sda(sda),
    .busResetN(busResetN), .pins(pins), .changeAlertN(alertN),
    .pull(devPull));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a whole read can take some 13000 cycles, so the ceiling is generous
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] w,
                      input logic [7:0] ctl);
    logic [7:0] s;
    wr(REG_CMD, c);
    wr(REG_WDATA, w);
    wr(REG_CTRL, ctl | 8'h01);
    repeat (4) @(posedge clk);
    s = 8'h00;
    for (int i = 0; i < 20000 && s[STAT_DONE] !== 1'b1; i++) rd(REG_STAT, s);
    chk({7'h00, s[STAT_DONE]}, 8'h01);
  endtask
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    pins = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({6'h00, scl, sda}, 8'h03);
    rd(REG_STAT, d);
    chk(d, 8'h00);
    rd(4'hF, d);
    chk(d, 8'h00);
    xfer(CMD_OUT_A, 8'h00, 8'h06);
    rd(REG_RDATA, d);
    chk(d, 8'hF0);
    rd(REG_STAT, d);
    chk(d, 8'h08);
    xfer(CMD_DIR_A, 8'hFF, 8'h04);
    chk(dev.regs[4], 8'hF0);
    chk({7'h00, dev.lowErr}, 8'h00);
    pins <= 8'h0F;
    repeat (10) @(posedge clk);
    chk({7'h00, alertN}, 8'h01);
    pins <= 8'hAF;
    repeat (10) @(posedge clk);
    rd(REG_STAT, d);
    chk(d, 8'h0C);
    xfer(CMD_IN_A, 8'h00, 8'h06);
    rd(REG_RDATA, d);
    chk(d, 8'hA0);
    rd(REG_STAT, d);
    chk(d, 8'h08);
    xfer(CMD_OUT_B, 8'h50, 8'h00);
    rd(REG_STAT, d);
    chk(d, 8'h0A);
    chk(dev.regs[3], 8'hF0);
    wr(REG_CMD, CMD_OUT_B);
    wr(REG_CTRL, 8'h05);
    repeat (1000) @(posedge clk);
    wr(REG_CTRL, 8'h0C);
    repeat (3) @(posedge clk);
    #1 chk({5'h00, busResetN, scl, dev.act}, 8'h02);
    chk({7'h00, alertN}, 8'h01);
    wr(REG_CTRL, 8'h04);
    rd(REG_STAT, d);
    chk(d & 8'h01, 8'h00);
    rd(REG_CTRL, d);
    chk(d, 8'h04);
    end_sim();
  end
endmodule
`default_nettype wire
